/* File: core/baud_fine_pkg.sv */
// Package of register map, field layout and delay pattern for the baud count clock block.
package baud_fine_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int           ADDR_W         = 18;
    localparam logic [15:0]  RELOAD_IDX     = 16'h4106;
    localparam logic [15:0]  FINE_IDX       = 16'h4107;
    localparam logic [15:0]  CLKCTL_IDX     = 16'h506C;
    localparam logic [17:0]  RELOAD_ADDR    = {RELOAD_IDX, 2'b00};
    localparam logic [17:0]  FINE_ADDR      = {FINE_IDX, 2'b00};
    localparam logic [17:0]  CLKCTL_ADDR    = {CLKCTL_IDX, 2'b00};

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int           GATE_POS       = 0;
    localparam int           SRC_LSB        = 2;
    localparam int           PSC_LSB        = 4;
    localparam logic [7:0]   RELOAD_RST     = 8'h00;
    localparam logic [3:0]   FINE_RST       = 4'h0;
    localparam logic [1:0]   SRC_RST        = 2'h0;
    localparam logic [1:0]   PSC_RST        = 2'h0;

    typedef enum logic [1:0] {
        SRC_FAST     = 2'h0,
        SRC_SLOW     = 2'h1,
        SRC_RESERVED = 2'h2,
        SRC_EXT      = 2'h3
    } count_source_t;

    typedef struct packed {
        logic [1:0]    prescale_ratio_select;
        count_source_t count_source_select;
        logic          count_clock_gate;
    } clk_ctrl_t;

    localparam logic [4:0]   CLK_CTRL_RST   = {PSC_RST, SRC_RST, 1'b0};

    // Order in which positions join the delay pattern, as a rank per position.
    // A position is delayed when its rank does not exceed the fine value.
    // Position 1 has rank 16 and so is never delayed.
    function automatic logic [4:0] pos_rank(input logic [3:0] pos_m1);
        logic [4:0] r;
        r = 5'h10;
        case (pos_m1)
            4'h0: r = 5'h10;
            4'h1: r = 5'h08;
            4'h2: r = 5'h0C;
            4'h3: r = 5'h04;
            4'h4: r = 5'h0E;
            4'h5: r = 5'h06;
            4'h6: r = 5'h0A;
            4'h7: r = 5'h02;
            4'h8: r = 5'h0F;
            4'h9: r = 5'h07;
            4'hA: r = 5'h0B;
            4'hB: r = 5'h03;
            4'hC: r = 5'h0D;
            4'hD: r = 5'h05;
            4'hE: r = 5'h09;
            4'hF: r = 5'h01;
            default: r = 5'h10;
        endcase
        return r;
    endfunction : pos_rank

endpackage : baud_fine_pkg

/* File: core/baud_fine_clock.sv */
// Count clock selection, prescaler, reload counter and fine rate correction with APB registers.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module baud_fine_clock #(
    parameter int RELOAD_W = 8
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rstn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [baud_fine_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            fast_oscillator,
    input  wire logic                            slow_oscillator,
    input  wire logic                            external_count_clock_pin,
    output logic                                 sample_tick,
    output logic      [3:0]                      underflow_position
);
    import baud_fine_pkg::*;

    if (RELOAD_W < 1 || RELOAD_W > 8) begin : g_bad_width
        $error("RELOAD_W must lie between 1 and 8");
    end

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [RELOAD_W-1:0] reload_r;
    logic [3:0]          fine_r;
    clk_ctrl_t           ctrl_r;
    logic [31:0]         prdata_nxt;

    wire setup_ph   = psel & ~penable;
    wire access_ph  = psel & penable;
    wire hit_reload = (paddr == RELOAD_ADDR);
    wire hit_fine   = (paddr == FINE_ADDR);
    wire hit_ctrl   = (paddr == CLKCTL_ADDR);
    wire hit_any    = hit_reload | hit_fine | hit_ctrl;
    wire wr_lane0   = access_ph & pwrite & pstrb[0];
    wire wr_reload  = wr_lane0 & hit_reload;
    wire wr_fine    = wr_lane0 & hit_fine;
    wire wr_ctrl    = wr_lane0 & hit_ctrl;

    assign pready  = 1'b1;
    assign pslverr = access_ph & ~hit_any;

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_reload) begin
            prdata_nxt[RELOAD_W-1:0] = reload_r;
        end else if (hit_fine) begin
            prdata_nxt[3:0] = fine_r;
        end else if (hit_ctrl) begin
            prdata_nxt[PSC_LSB+1:PSC_LSB] = ctrl_r.prescale_ratio_select;
            prdata_nxt[SRC_LSB+1:SRC_LSB] = ctrl_r.count_source_select;
            prdata_nxt[GATE_POS]          = ctrl_r.count_clock_gate;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reload_r <= RELOAD_RST[RELOAD_W-1:0];
            fine_r   <= FINE_RST;
            ctrl_r   <= clk_ctrl_t'(CLK_CTRL_RST);
            prdata   <= 32'h0000_0000;
        end else begin
            if (wr_reload) begin
                reload_r <= pwdata[RELOAD_W-1:0];
            end
            if (wr_fine) begin
                fine_r <= pwdata[3:0];
            end
            if (wr_ctrl) begin
                ctrl_r <= clk_ctrl_t'({pwdata[PSC_LSB+1:PSC_LSB],
                                       pwdata[SRC_LSB+1:SRC_LSB],
                                       pwdata[GATE_POS]});
            end
            if (setup_ph && !pwrite) begin
                prdata <= prdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Source synchronisers and edge detection
    // ------------------------------------------------------------------
    // Each source arrives asynchronously, so it is sampled by two flops and
    // its rising edge is taken from the second. A source must therefore run
    // below half of ref_clk; faster sources lose edges.
    logic [2:0] src_in;
    logic [2:0] src_edge;

    assign src_in = {external_count_clock_pin, slow_oscillator, fast_oscillator};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        // Each source keeps its flops inside its own loop pass, so every flop has one driver.
        logic sync1_r;
        logic sync2_r;
        logic sync3_r;

        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                sync1_r <= 1'b0;
                sync2_r <= 1'b0;
                sync3_r <= 1'b0;
            end else begin
                sync1_r <= src_in[g];
                sync2_r <= sync1_r;
                sync3_r <= sync2_r;
            end
        end
        assign src_edge[g] = sync2_r & ~sync3_r;
    end

    // ------------------------------------------------------------------
    // Prescaler and count clock selection
    // ------------------------------------------------------------------
    logic [2:0] div_cnt_r;
    logic [2:0] div_mask;

    always_comb begin
        case (ctrl_r.prescale_ratio_select)
            2'h0:    div_mask = 3'h0;
            2'h1:    div_mask = 3'h1;
            2'h2:    div_mask = 3'h3;
            2'h3:    div_mask = 3'h7;
            default: div_mask = 3'h0;
        endcase
    end

    wire fast_div = src_edge[0] & ((div_cnt_r & div_mask) == div_mask);

    always_ff @(posedge ref_clk) begin
        if (!rstn || !ctrl_r.count_clock_gate) begin
            div_cnt_r <= 3'h0;
        end else if (src_edge[0]) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end

    logic src_pulse;

    always_comb begin
        case (ctrl_r.count_source_select)
            SRC_FAST: src_pulse = fast_div;
            SRC_SLOW: src_pulse = src_edge[1];
            SRC_EXT:  src_pulse = src_edge[2];
            default:  src_pulse = 1'b0;
        endcase
    end

    wire ce = src_pulse & ctrl_r.count_clock_gate;

    // ------------------------------------------------------------------
    // Reload counter with fine delay insertion
    // ------------------------------------------------------------------
    logic [RELOAD_W-1:0] cnt_r;
    logic [3:0]          pos_r;
    logic                stretch_r;

    wire dly_pos = (pos_rank(pos_r) <= {1'b0, fine_r});
    wire at_zero = (cnt_r == '0);
    wire do_stretch = ce & at_zero & dly_pos & ~stretch_r;
    wire tick = ce & at_zero & ~(dly_pos & ~stretch_r);

    always_ff @(posedge ref_clk) begin
        if (!rstn || !ctrl_r.count_clock_gate) begin
            cnt_r     <= reload_r;
            pos_r     <= 4'h0;
            stretch_r <= 1'b0;
        end else if (tick) begin
            cnt_r     <= reload_r;
            pos_r     <= pos_r + 4'h1;
            stretch_r <= 1'b0;
        end else if (do_stretch) begin
            stretch_r <= 1'b1;
        end else if (ce) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sample_tick        <= 1'b0;
            underflow_position <= 4'h0;
        end else begin
            sample_tick        <= tick;
            underflow_position <= pos_r;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Count clock pulses in the running period; valid only for a period
    // with no reload or fine write in it. Closing the gate restarts the count as valid.
    logic [9:0] per_len_r;
    logic       per_ok_r;

    always_ff @(posedge ref_clk) begin
        if (!rstn || !ctrl_r.count_clock_gate) begin
            per_len_r <= 10'h000;
            per_ok_r  <= 1'b1;
        end else if (tick) begin
            per_len_r <= 10'h000;
            per_ok_r  <= ~(wr_reload | wr_fine);
        end else begin
            if (ce) begin
                per_len_r <= per_len_r + 10'h001;
            end
            if (wr_reload || wr_fine) begin
                per_ok_r <= 1'b0;
            end
        end
    end

    property p_period_len;
        @(posedge ref_clk) disable iff (!rstn)
        (tick && per_ok_r) |->
            (per_len_r == 10'(reload_r) + 10'(dly_pos));
    endproperty
    a_period_len: assert property (p_period_len)
        else $error("underflow period length wrong");

    property p_gate_off;
        @(posedge ref_clk) disable iff (!rstn)
        !ctrl_r.count_clock_gate |=> !sample_tick && pos_r == 4'h0;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("tick or position while gated off");

    property p_pos_step;
        @(posedge ref_clk) disable iff (!rstn)
        (tick && ctrl_r.count_clock_gate) |=>
            (pos_r == $past(pos_r) + 4'h1) && (underflow_position == $past(pos_r));
    endproperty
    a_pos_step: assert property (p_pos_step)
        else $error("position did not advance on underflow");

    property p_rsvd_src;
        @(posedge ref_clk) disable iff (!rstn)
        (ctrl_r.count_source_select == SRC_RESERVED) |-> !ce;
    endproperty
    a_rsvd_src: assert property (p_rsvd_src)
        else $error("reserved source produced count clock");

    property p_no_fine;
        @(posedge ref_clk) disable iff (!rstn)
        (fine_r == 4'h0) |-> !do_stretch;
    endproperty
    a_no_fine: assert property (p_no_fine)
        else $error("delay inserted with fine value zero");

    property p_pos_one;
        @(posedge ref_clk) disable iff (!rstn)
        (pos_r == 4'h0) |-> !dly_pos;
    endproperty
    a_pos_one: assert property (p_pos_one)
        else $error("first position delayed");

    property p_fine_pattern;
        @(posedge ref_clk) disable iff (!rstn)
        (pos_r == 4'hF && fine_r != 4'h0) || (pos_r == 4'h7 && fine_r >= 4'h2)
            || (pos_r == 4'hE && fine_r >= 4'h9) |-> dly_pos;
    endproperty
    a_fine_pattern: assert property (p_fine_pattern)
        else $error("expected delayed position not delayed");

    property p_prescale;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && ctrl_r.count_source_select == SRC_FAST
            && ctrl_r.prescale_ratio_select == 2'h3) |-> div_cnt_r == 3'h7;
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("divide by eight pulse off phase");

    property p_slow_direct;
        @(posedge ref_clk) disable iff (!rstn)
        (ctrl_r.count_clock_gate && ctrl_r.count_source_select == SRC_SLOW)
            |-> ce == src_edge[1];
    endproperty
    a_slow_direct: assert property (p_slow_direct)
        else $error("slow source not passed undivided");

    property p_stretch_once;
        @(posedge ref_clk) disable iff (!rstn)
        do_stretch |=> stretch_r ##0 (!do_stretch throughout (stretch_r [*1]));
    endproperty
    a_stretch_once: assert property (p_stretch_once)
        else $error("delay inserted twice in one period");

    // Count inserted delays over one aligned group of sixteen periods. The
    // sum is judged only when the fine value stood still for the whole group.
    logic [4:0] grp_dly_r;
    logic       grp_ok_r;

    always_ff @(posedge ref_clk) begin
        if (!rstn || !ctrl_r.count_clock_gate) begin
            grp_dly_r <= 5'h00;
            grp_ok_r  <= 1'b1;
        end else if (tick && pos_r == 4'hF) begin
            grp_dly_r <= 5'h00;
            grp_ok_r  <= ~wr_fine;
        end else begin
            if (do_stretch) begin
                grp_dly_r <= grp_dly_r + 5'h01;
            end
            if (wr_fine) begin
                grp_ok_r <= 1'b0;
            end
        end
    end

    property p_group_delays;
        @(posedge ref_clk) disable iff (!rstn)
        (tick && pos_r == 4'hF && grp_ok_r) |-> grp_dly_r == {1'b0, fine_r};
    endproperty
    a_group_delays: assert property (p_group_delays)
        else $error("delay count per group differs from fine value");

    property p_reload_on_tick;
        @(posedge ref_clk) disable iff (!rstn)
        tick |=> cnt_r == $past(reload_r);
    endproperty
    a_reload_on_tick: assert property (p_reload_on_tick)
        else $error("counter not reloaded after underflow");

    // A source switch may put two count pulses back to back, so that case is left out.
    property p_tick_pulse;
        @(posedge ref_clk) disable iff (!rstn)
        (sample_tick && !$past(wr_ctrl)) |=> !sample_tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("sample tick longer than one cycle");

endmodule : baud_fine_clock

/* File: verification/testbench.sv */
// Self-checking testbench for the baud count clock and fine rate block.
`timescale 1ns/10ps
module testbench;
    import baud_fine_pkg::*;
    // --------------------
    // Signals
    // --------------------
    logic              ref_clk;
    logic              rstn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [2:0]        osc;
    logic              sample_tick;
    logic [3:0]        underflow_position;
    logic [31:0]       rd;
    logic [31:0]       d;
    logic              err;
    int                n_fail;
    int                tests_run;
    int                seed;
    int                half [3] = '{2, 3, 5};
    int                tgl [3] = '{0, 0, 0};

    baud_fine_clock u_dut (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .fast_oscillator(osc[0]),
        .slow_oscillator(osc[1]),
        .external_count_clock_pin(osc[2]),
        .sample_tick(sample_tick),
        .underflow_position(underflow_position)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Sources run free; each level lasts two or more clocks so the synchronisers see it.
    always @(posedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            tgl[i] = (tgl[i] + 1) % half[i];
            if (tgl[i] == 0) osc[i] <= ~osc[i];
        end
    end

    // --------------------
    // Tasks
    // --------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask : wr

    task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(what, e, rd);
        check("mapped err", 32'h0, {31'h0, err});
    endtask : rchk

    // Positions in the order in which they join the delay pattern.
    function automatic int delayed(input logic [3:0] f, input int pos);
        int order [15] = '{16, 8, 12, 4, 14, 6, 10, 2, 15, 7, 11, 3, 13, 5, 9};
        for (int k = 0; k < 15; k++) begin
            if (k < f && order[k] == pos) return 1;
        end
        return 0;
    endfunction : delayed

    task automatic wait_tick(output int cyc);
        cyc = 0;
        do begin
            @(negedge ref_clk);
            cyc++;
        end while (sample_tick !== 1'b1 && cyc < 1000);
        check("tick seen", 32'h1, {31'h0, sample_tick});
    endtask : wait_tick

    task automatic quiet(input logic [31:0] ctl);
        int n;
        n = 0;
        wr(CLKCTL_ADDR, ctl);
        // A tick already under way at the write edge may still show; count from the next edge.
        @(posedge ref_clk);
        repeat (400) begin
            @(negedge ref_clk);
            if (sample_tick === 1'b1) n++;
        end
        check("ticks while stopped", 32'h0, n);
    endtask : quiet

    // The first period after enabling starts at an unknown source phase, so only its
    // position is judged; the next sixteen periods are timed exactly.
    task automatic run_rate(input count_source_t src, input logic [1:0] psc,
                            input logic [3:0] f);
        logic [31:0] t;
        int          r, div, per, cyc, sum;
        t = $random(seed);
        r = t[1:0];
        div = (src == SRC_FAST) ? (1 << psc) : 1;
        per = 2 * half[(src == SRC_EXT) ? 2 : int'(src)];
        wr(RELOAD_ADDR, {30'h0, t[1:0]});
        wr(FINE_ADDR, {28'h0, f});
        wr(CLKCTL_ADDR, {26'h0, psc, src, 1'b0, 1'b1});
        wait_tick(cyc);
        check("first position", 32'h0, {28'h0, underflow_position});
        sum = 0;
        for (int i = 1; i <= 16; i++) begin
            wait_tick(cyc);
            sum += cyc;
            check("position", i % 16, {28'h0, underflow_position});
            check("period", (r + 1 + delayed(f, i % 16 + 1)) * div * per, cyc);
        end
        check("group length", (16 * (r + 1) + f) * div * per, sum);
        wr(CLKCTL_ADDR, 32'h0);
    endtask : run_rate

    task automatic conclude();
        $display("Counts: %0d comparisons, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // --------------------
    // Sequence
    // --------------------
    initial begin
        #(40000 * 50);
        n_fail++;
        conclude();
    end

    initial begin
        logic [ADDR_W-1:0] addrs [3];
        logic [31:0]       masks [3];
        addrs = '{RELOAD_ADDR, FINE_ADDR, CLKCTL_ADDR};
        masks = '{32'hFF, 32'h0F, 32'h3D};
        seed = 32'h3055;
        n_fail = 0;
        tests_run = 0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        osc = 3'h0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rchk("reload reset", RELOAD_ADDR, 32'h0);
        rchk("fine reset", FINE_ADDR, 32'h0);
        rchk("clkctl reset", CLKCTL_ADDR, 32'h0);
        apb(1'b0, 18'h00004, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            wr(addrs[i % 3], d);
            rchk("readback", addrs[i % 3], d & masks[i % 3]);
        end
        wr(FINE_ADDR, 32'h0);
        pstrb <= 4'h0;
        wr(FINE_ADDR, 32'hF);
        pstrb <= 4'hF;
        rchk("strobe-less write", FINE_ADDR, 32'h0);
        wr(RELOAD_ADDR, 32'h0);
        quiet(32'h0);
        quiet(32'h9);
        for (int f = 0; f < 16; f++) begin
            run_rate(SRC_FAST, 2'h0, 4'(f));
        end
        for (int p = 0; p < 4; p++) begin
            d = $random(seed);
            run_rate(SRC_FAST, 2'(p), d[3:0]);
        end
        d = $random(seed);
        run_rate(SRC_SLOW, 2'h3, d[3:0]);
        run_rate(SRC_EXT, 2'h1, d[7:4]);
        conclude();
    end
endmodule : testbench
